// >>> logic/plc_top.sv
`timescale 1ns/1ns
`default_nettype none
module plc_top #(
    parameter logic [31:0] IMPL_MASK = 32'hffff_ffff,
    parameter logic [31:0] MUX_MASK  = 32'hffff_ffff,
    parameter logic [31:0] OWN_RST   = 32'hffff_ffff,
    parameter logic [31:0] PU_RST    = 32'hffff_ffff,
    parameter logic [31:0] PD_RST    = 32'h0000_0000
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        CLK_EN,
    // register port
    input  wire logic [8:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // pins
    input  wire logic [31:0] PIN_IN,
    output logic      [31:0] PIN_OUT,
    output logic      [31:0] PIN_OE_N,
    // pad and mux control
    output logic      [31:0] OWN_LINES,
    output logic      [31:0] PULLUP_EN,
    output logic      [31:0] PULLDN_EN,
    output logic      [31:0] SEL_LO,
    output logic      [31:0] SEL_HI,
    output logic      [31:0] HYST_EN,
    // interrupt
    output logic             IRQ
);
    plc_pkg::plc_state_t s_r, s_nxt;
    logic [31:0] wd, rise, fall, ev;
    logic        prot;

    localparam plc_pkg::plc_state_t RST_S = '{
        own: OWN_RST | ~MUX_MASK, pu: PU_RST, pd: PD_RST,
        hyst: plc_pkg::HYST_RST, pin_oe_n: ~plc_pkg::ZERO,
        own_out: OWN_RST | ~MUX_MASK,
        default: '0
    };

    function automatic logic guarded(input logic [8:0] a);
        guarded = (a == plc_pkg::OFS_OWN_EN) || (a == plc_pkg::OFS_OWN_DIS)
               || (a == plc_pkg::OFS_OE_EN)  || (a == plc_pkg::OFS_OE_DIS)
               || (a == plc_pkg::OFS_GF_EN)  || (a == plc_pkg::OFS_GF_DIS)
               || (a == plc_pkg::OFS_OD_EN)  || (a == plc_pkg::OFS_OD_DIS)
               || (a == plc_pkg::OFS_PU_DIS) || (a == plc_pkg::OFS_PU_EN)
               || (a == plc_pkg::OFS_SEL_LO) || (a == plc_pkg::OFS_SEL_HI)
               || (a == plc_pkg::OFS_OW_EN)  || (a == plc_pkg::OFS_OW_DIS)
               || (a == plc_pkg::OFS_PD_DIS) || (a == plc_pkg::OFS_PD_EN);
    endfunction : guarded

    // set and clear pair acting on one status word
    function automatic logic [31:0] setclr(input logic [31:0] cur,
                                           input logic [8:0]  a,
                                           input logic [8:0]  aset,
                                           input logic [8:0]  aclr,
                                           input logic [31:0] d);
        if (a == aset) begin
            setclr = cur | d;
        end else if (a == aclr) begin
            setclr = cur & ~d;
        end else begin
            setclr = cur;
        end
    endfunction : setclr

    // edges are taken against the held sample; the CLK_EN mask on ev makes none while the clock is stopped
    assign rise = s_r.s2 & ~s_r.pdsr;
    assign fall = ~s_r.s2 & s_r.pdsr;
    always_comb begin
        for (int i = 0; i < plc_pkg::NL; i++) begin
            if (!s_r.aim[i]) begin
                ev[i] = rise[i] | fall[i];
            end else if (s_r.els[i]) begin
                ev[i] = s_r.pol[i] ? s_r.s2[i] : ~s_r.s2[i];
            end else begin
                ev[i] = s_r.pol[i] ? rise[i] : fall[i];
            end
        end
        ev = ev & IMPL_MASK & {plc_pkg::NL{CLK_EN}};
    end

    assign wd   = WDATA & IMPL_MASK;
    assign prot = s_r.write_protect_enable && guarded(ADDR);

    always_comb begin
        s_nxt = s_r;
        // pins cross in through two flops; s1 feeds only s2
        s_nxt.s1 = PIN_IN;
        s_nxt.s2 = s_r.s1;
        if (CLK_EN) begin
            s_nxt.pdsr = s_r.s2 & IMPL_MASK;
        end
        if (WR && prot) begin
            s_nxt.wpvs  = 1'b1;
            s_nxt.wpsrc = ADDR;
        end else if (WR) begin
            s_nxt.own = setclr(s_r.own, ADDR, plc_pkg::OFS_OWN_EN,
                               plc_pkg::OFS_OWN_DIS, wd);
            s_nxt.oe  = setclr(s_r.oe, ADDR, plc_pkg::OFS_OE_EN,
                               plc_pkg::OFS_OE_DIS, wd);
            s_nxt.gf  = setclr(s_r.gf, ADDR, plc_pkg::OFS_GF_EN,
                               plc_pkg::OFS_GF_DIS, wd);
            s_nxt.odsr = setclr(s_r.odsr, ADDR, plc_pkg::OFS_OUT_SET,
                                plc_pkg::OFS_OUT_CLR, wd);
            s_nxt.imr = setclr(s_r.imr, ADDR, plc_pkg::OFS_IE_SET,
                               plc_pkg::OFS_IE_CLR, wd);
            s_nxt.od  = setclr(s_r.od, ADDR, plc_pkg::OFS_OD_EN,
                               plc_pkg::OFS_OD_DIS, wd);
            s_nxt.pu  = setclr(s_r.pu, ADDR, plc_pkg::OFS_PU_EN,
                               plc_pkg::OFS_PU_DIS, wd);
            s_nxt.sf  = setclr(s_r.sf, ADDR, plc_pkg::OFS_SF_EN,
                               plc_pkg::OFS_SF_DIS, wd);
            s_nxt.pd  = setclr(s_r.pd, ADDR, plc_pkg::OFS_PD_EN,
                               plc_pkg::OFS_PD_DIS, wd);
            s_nxt.ow  = setclr(s_r.ow, ADDR, plc_pkg::OFS_OW_EN,
                               plc_pkg::OFS_OW_DIS, wd);
            s_nxt.aim = setclr(s_r.aim, ADDR, plc_pkg::OFS_AIM_EN,
                               plc_pkg::OFS_AIM_DIS, wd);
            s_nxt.els = setclr(s_r.els, ADDR, plc_pkg::OFS_LEVEL,
                               plc_pkg::OFS_EDGE, wd);
            s_nxt.pol = setclr(s_r.pol, ADDR, plc_pkg::OFS_RISE,
                               plc_pkg::OFS_FALL, wd);
            if (ADDR == plc_pkg::OFS_OUT_ST) begin
                s_nxt.odsr = (s_r.odsr & ~s_r.ow) | (wd & s_r.ow);
            end else if (ADDR == plc_pkg::OFS_SEL_LO) begin
                s_nxt.sello = wd;
            end else if (ADDR == plc_pkg::OFS_SEL_HI) begin
                s_nxt.selhi = wd;
            end else if (ADDR == plc_pkg::OFS_DIV) begin
                s_nxt.div = WDATA & plc_pkg::DIV_MASK;
            end else if (ADDR == plc_pkg::OFS_WG_MODE) begin
                s_nxt.write_protect_enable = WDATA[plc_pkg::WG_EN_BIT];
            end else if (ADDR == plc_pkg::OFS_HYST) begin
                s_nxt.hyst = wd;
            end
        end
        s_nxt.own = s_nxt.own | ~MUX_MASK;
        // read side: registered answer, one cycle after the strobe
        s_nxt.rdata = plc_pkg::ZERO;
        if (RD) begin
            if (ADDR == plc_pkg::OFS_OWN_ST) begin
                s_nxt.rdata = s_r.own;
            end else if (ADDR == plc_pkg::OFS_OE_ST) begin
                s_nxt.rdata = s_r.oe;
            end else if (ADDR == plc_pkg::OFS_GF_ST) begin
                s_nxt.rdata = s_r.gf;
            end else if (ADDR == plc_pkg::OFS_OUT_ST) begin
                s_nxt.rdata = s_r.odsr;
            end else if (ADDR == plc_pkg::OFS_PIN) begin
                s_nxt.rdata = s_r.pdsr;
            end else if (ADDR == plc_pkg::OFS_IE_ST) begin
                s_nxt.rdata = s_r.imr;
            end else if (ADDR == plc_pkg::OFS_PEND) begin
                s_nxt.rdata = s_r.isr;
            end else if (ADDR == plc_pkg::OFS_OD_ST) begin
                s_nxt.rdata = s_r.od;
            end else if (ADDR == plc_pkg::OFS_PU_ST) begin
                s_nxt.rdata = s_r.pu;
            end else if (ADDR == plc_pkg::OFS_SEL_LO) begin
                s_nxt.rdata = s_r.sello;
            end else if (ADDR == plc_pkg::OFS_SEL_HI) begin
                s_nxt.rdata = s_r.selhi;
            end else if (ADDR == plc_pkg::OFS_SF_ST) begin
                s_nxt.rdata = s_r.sf;
            end else if (ADDR == plc_pkg::OFS_DIV) begin
                s_nxt.rdata = s_r.div;
            end else if (ADDR == plc_pkg::OFS_PD_ST) begin
                s_nxt.rdata = s_r.pd;
            end else if (ADDR == plc_pkg::OFS_OW_ST) begin
                s_nxt.rdata = s_r.ow;
            end else if (ADDR == plc_pkg::OFS_AIM_ST) begin
                s_nxt.rdata = s_r.aim;
            end else if (ADDR == plc_pkg::OFS_EL_ST) begin
                s_nxt.rdata = s_r.els;
            end else if (ADDR == plc_pkg::OFS_POL_ST) begin
                s_nxt.rdata = s_r.pol;
            end else if (ADDR == plc_pkg::OFS_WG_MODE) begin
                s_nxt.rdata[plc_pkg::WG_EN_BIT] = s_r.write_protect_enable;
            end else if (ADDR == plc_pkg::OFS_WG_ST) begin
                s_nxt.rdata[plc_pkg::WG_VS_BIT] = s_r.wpvs;
                s_nxt.rdata[plc_pkg::WG_SRC_LSB +: plc_pkg::AW] = s_r.wpsrc;
                s_nxt.wpvs = WR && prot;
            end else if (ADDR == plc_pkg::OFS_HYST) begin
                s_nxt.rdata = s_r.hyst;
            end else begin
                s_nxt.rdata = plc_pkg::ZERO;
            end
            if (ADDR != plc_pkg::OFS_DIV && ADDR != plc_pkg::OFS_WG_MODE
                && ADDR != plc_pkg::OFS_WG_ST) begin
                s_nxt.rdata = s_nxt.rdata & IMPL_MASK;
            end
        end
        // new events win over the clear-on-read
        if (RD && ADDR == plc_pkg::OFS_PEND) begin
            s_nxt.isr = ev;
        end else begin
            s_nxt.isr = s_r.isr | ev;
        end
        s_nxt.irq      = |(s_nxt.isr & s_nxt.imr);
        s_nxt.own_out  = s_nxt.own;
        s_nxt.pin_out  = s_nxt.odsr;
        // open-drain lines only ever pull low
        s_nxt.pin_oe_n = ~(s_nxt.own & s_nxt.oe & (~s_nxt.od | ~s_nxt.odsr) & IMPL_MASK);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_r <= RST_S;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RDATA     = s_r.rdata;
    assign PIN_OUT   = s_r.pin_out;
    assign PIN_OE_N  = s_r.pin_oe_n;
    assign OWN_LINES = s_r.own_out;
    assign PULLUP_EN = s_r.pu;
    assign PULLDN_EN = s_r.pd;
    assign SEL_LO    = s_r.sello;
    assign SEL_HI    = s_r.selhi;
    assign HYST_EN   = s_r.hyst;
    assign IRQ       = s_r.irq;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    unimpl_read_zero_a: assert property (RD |=> (RDATA & ~IMPL_MASK) == '0)
        else $error("unbuilt line read nonzero");
    unimpl_write_a: assert property (WR |=> (s_r.oe & ~IMPL_MASK) == '0)
        else $error("unbuilt line took a write");
    own_fixed_a: assert property ((OWN_LINES & ~MUX_MASK) == ~MUX_MASK)
        else $error("unmuxed line not owned");
    own_take_a: assert property (WR && !s_r.write_protect_enable && ADDR == plc_pkg::OFS_OWN_EN
        |=> ##1 (OWN_LINES & $past(wd, 2)) == $past(wd, 2))
        else $error("ownership enable not seen on output");
    guard_drop_a: assert property (WR && s_r.write_protect_enable && ADDR == plc_pkg::OFS_OE_EN
        |=> s_r.oe == $past(s_r.oe) && s_r.wpvs)
        else $error("guarded write took effect");
    out_lock_a: assert property (WR && ADDR == plc_pkg::OFS_OUT_ST
        |=> ((s_r.odsr ^ $past(s_r.odsr)) & ~$past(s_r.ow)) == '0)
        else $error("locked output bit changed");
    pin_hold_a: assert property (!CLK_EN |=> s_r.pdsr == $past(s_r.pdsr))
        else $error("pin sample moved with clock stopped");
    pend_clear_a: assert property (RD && ADDR == plc_pkg::OFS_PEND
        |=> (s_r.isr & ~$past(ev)) == '0)
        else $error("pending flag survived read");
    wo_read_zero_a: assert property (RD && ADDR == plc_pkg::OFS_OUT_SET |=> RDATA == '0)
        else $error("write-only word read nonzero");
    // a mask clear in the event cycle may legally keep the line low
    irq_follow_a: assert property (|(ev & s_r.imr)
        && !(WR && ADDR == plc_pkg::OFS_IE_CLR) |=> IRQ)
        else $error("interrupt low after unmasked event");
    own_drop_a: assert property (WR && !s_r.write_protect_enable && ADDR == plc_pkg::OFS_OWN_DIS
        |=> (OWN_LINES & $past(wd) & MUX_MASK) == '0)
        else $error("ownership disable not seen on output");
    clr_word_a: assert property (WR && !s_r.write_protect_enable && ADDR == plc_pkg::OFS_OE_DIS
        |=> (s_r.oe & $past(wd)) == '0)
        else $error("drive disable left a bit set");
    guard_log_a: assert property (WR && prot
        |=> s_r.wpvs && s_r.wpsrc == $past(ADDR))
        else $error("guard violation not logged");

    edge_irq_c: cover property (!s_r.aim[8] && ev[8] ##1 IRQ);
    guard_hit_c: cover property (WR && prot);
    level_c: cover property (s_r.aim[9] && s_r.els[9] && ev[9] [*3]);
    pend_read_c: cover property (RD && ADDR == plc_pkg::OFS_PEND && s_r.isr != '0);
endmodule : plc_top
`default_nettype wire

// >>> logic/plc_pkg.sv
// How it works
// - every register is one 32-bit word and, except in the divider and write-guard words, bit n belongs to line n.
// - writes to bits of lines that are not built change nothing.
// - bits of lines that are not built always read as zero.
// - a line with no peripheral behind it is always owned and its ownership bit reads one.
// - the output level word takes written data only on lines unlocked in the write status.
// - the pin sample follows the lines only while the clock runs, else it holds.
// - the pending word resets to zero and may be nonzero at the first read.
// - offsets outside the map are reserved: writes ignored, reads give zero.
// - reset values of ownership, pull-up and pull-down are set per line by parameter.
// - a one in ownership enable gives the line to the controller, in disable to the peripheral.
// - with write protection on, writes to the guarded configuration registers are dropped.
// - reading the pending word clears the edge flags; level sources set again while true.
package plc_pkg;
    localparam int          NL   = 32;
    localparam int          AW   = 9;
    localparam logic [8:0] OFS_OWN_EN  = 9'h000;
    localparam logic [8:0] OFS_OWN_DIS = 9'h004;
    localparam logic [8:0] OFS_OWN_ST  = 9'h008;
    localparam logic [8:0] OFS_OE_EN   = 9'h010;
    localparam logic [8:0] OFS_OE_DIS  = 9'h014;
    localparam logic [8:0] OFS_OE_ST   = 9'h018;
    localparam logic [8:0] OFS_GF_EN   = 9'h020;
    localparam logic [8:0] OFS_GF_DIS  = 9'h024;
    localparam logic [8:0] OFS_GF_ST   = 9'h028;
    localparam logic [8:0] OFS_OUT_SET = 9'h030;
    localparam logic [8:0] OFS_OUT_CLR = 9'h034;
    localparam logic [8:0] OFS_OUT_ST  = 9'h038;
    localparam logic [8:0] OFS_PIN     = 9'h03c;
    localparam logic [8:0] OFS_IE_SET  = 9'h040;
    localparam logic [8:0] OFS_IE_CLR  = 9'h044;
    localparam logic [8:0] OFS_IE_ST   = 9'h048;
    localparam logic [8:0] OFS_PEND    = 9'h04c;
    localparam logic [8:0] OFS_OD_EN   = 9'h050;
    localparam logic [8:0] OFS_OD_DIS  = 9'h054;
    localparam logic [8:0] OFS_OD_ST   = 9'h058;
    localparam logic [8:0] OFS_PU_DIS  = 9'h060;
    localparam logic [8:0] OFS_PU_EN   = 9'h064;
    localparam logic [8:0] OFS_PU_ST   = 9'h068;
    localparam logic [8:0] OFS_SEL_LO  = 9'h070;
    localparam logic [8:0] OFS_SEL_HI  = 9'h074;
    localparam logic [8:0] OFS_SF_DIS  = 9'h080;
    localparam logic [8:0] OFS_SF_EN   = 9'h084;
    localparam logic [8:0] OFS_SF_ST   = 9'h088;
    localparam logic [8:0] OFS_DIV     = 9'h08c;
    localparam logic [8:0] OFS_PD_DIS  = 9'h090;
    localparam logic [8:0] OFS_PD_EN   = 9'h094;
    localparam logic [8:0] OFS_PD_ST   = 9'h098;
    localparam logic [8:0] OFS_OW_EN   = 9'h0a0;
    localparam logic [8:0] OFS_OW_DIS  = 9'h0a4;
    localparam logic [8:0] OFS_OW_ST   = 9'h0a8;
    localparam logic [8:0] OFS_AIM_EN  = 9'h0b0;
    localparam logic [8:0] OFS_AIM_DIS = 9'h0b4;
    localparam logic [8:0] OFS_AIM_ST  = 9'h0b8;
    localparam logic [8:0] OFS_EDGE    = 9'h0c0;
    localparam logic [8:0] OFS_LEVEL   = 9'h0c4;
    localparam logic [8:0] OFS_EL_ST   = 9'h0c8;
    localparam logic [8:0] OFS_FALL    = 9'h0d0;
    localparam logic [8:0] OFS_RISE    = 9'h0d4;
    localparam logic [8:0] OFS_POL_ST  = 9'h0d8;
    localparam logic [8:0] OFS_WG_MODE = 9'h0e4;
    localparam logic [8:0] OFS_WG_ST   = 9'h0e8;
    localparam logic [8:0] OFS_HYST    = 9'h100;
    localparam logic [31:0] ZERO       = 32'h0000_0000;
    localparam int          WG_EN_BIT  = 0;
    localparam int          WG_VS_BIT  = 0;
    localparam int          WG_SRC_LSB = 8;
    localparam logic [31:0] DIV_MASK   = 32'h0000_3fff;
    localparam logic [31:0] HYST_RST   = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] own, oe, gf, odsr, pdsr, imr, isr, od, pu, sello, selhi;
        logic [31:0] sf, div, pd, ow, aim, els, pol, hyst;
        logic        write_protect_enable, wpvs;
        logic [8:0]  wpsrc;
        logic [31:0] s1, s2, rdata, pin_out, pin_oe_n, own_out;
        logic        irq;
    } plc_state_t;
endpackage : plc_pkg

// >>> dv/plc_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
// pads seen from outside: the block wins where it drives, else the far device or a pull
module plc_pad_model (
    // clock
    input  wire logic        CLK,
    // block side
    input  wire logic [31:0] PIN_OUT,
    input  wire logic [31:0] PIN_OE_N,
    input  wire logic [31:0] PULLUP_EN,
    input  wire logic [31:0] PULLDN_EN,
    // far device, only ever seen on lines the block has released
    input  wire logic [31:0] EXT_EN,
    input  wire logic [31:0] EXT_VAL,
    output logic      [31:0] PIN_IN
);
    logic [31:0] wobble_r;
    logic [31:0] drv;

    // a floating line flips every cycle so a stale level can never pass as good
    initial wobble_r = 32'h5555_5555;
    always @(posedge CLK) begin
        wobble_r <= ~wobble_r;
    end

    assign drv    = ~PIN_OE_N;
    assign PIN_IN = (drv & PIN_OUT) | (~drv & EXT_EN & EXT_VAL)
                  | (~drv & ~EXT_EN & PULLUP_EN)
                  | (~drv & ~EXT_EN & ~PULLUP_EN & ~PULLDN_EN & wobble_r);
endmodule : plc_pad_model
`default_nettype wire

// >>> dv/parallel_io_register_map_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module parallel_io_register_map_tb_top;
    typedef struct packed {
        logic [8:0]  a;
        logic [31:0] d;
        logic [8:0]  ra;
        logic [31:0] ex;
    } plc_tb_op_t;

    logic        CLK, NRST, CLK_EN, WR, RD, IRQ;
    logic [8:0]  ADDR;
    logic [31:0] WDATA, RDATA, PIN_IN, PIN_OUT, PIN_OE_N, OWN_LINES, PULLUP_EN, PULLDN_EN;
    logic [31:0] SEL_LO, SEL_HI, HYST_EN, ext_en, ext_val, v;
    int          mismatches, n_tests;

    // lines 24..31 unbuilt, 8..15 have no peripheral, pulls on 0..3 and 4..5
    plc_top #(.IMPL_MASK(32'h00ff_ffff), .MUX_MASK(32'hffff_00ff), .OWN_RST(32'h0000_000f),
              .PU_RST(32'h0000_000f), .PD_RST(32'h0000_0030)) DUT (
        .CLK(CLK), .NRST(NRST), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
        .OWN_LINES(OWN_LINES), .PULLUP_EN(PULLUP_EN), .PULLDN_EN(PULLDN_EN),
        .SEL_LO(SEL_LO), .SEL_HI(SEL_HI), .HYST_EN(HYST_EN), .IRQ(IRQ));

    plc_pad_model PADS (.CLK(CLK), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
        .PULLUP_EN(PULLUP_EN), .PULLDN_EN(PULLDN_EN), .EXT_EN(ext_en), .EXT_VAL(ext_val),
        .PIN_IN(PIN_IN));

    localparam plc_tb_op_t RST [8] = '{
        '{9'h000, 32'h0, plc_pkg::OFS_OWN_ST,  32'h0000_ff0f},
        '{9'h000, 32'h0, plc_pkg::OFS_PU_ST,   32'h0000_000f},
        '{9'h000, 32'h0, plc_pkg::OFS_PD_ST,   32'h0000_0030},
        '{9'h000, 32'h0, plc_pkg::OFS_OE_ST,   32'h0000_0000},
        '{9'h000, 32'h0, plc_pkg::OFS_WG_MODE, 32'h0000_0000},
        '{9'h000, 32'h0, plc_pkg::OFS_OWN_EN,  32'h0000_0000},
        '{9'h000, 32'h0, plc_pkg::OFS_OUT_SET, 32'h0000_0000},
        '{9'h000, 32'h0, 9'h00c,               32'h0000_0000}};

    localparam plc_tb_op_t OPS [21] = '{
        '{plc_pkg::OFS_SEL_LO, 32'hffff_ffff, plc_pkg::OFS_SEL_LO, 32'h00ff_ffff},
        '{plc_pkg::OFS_DIV,    32'hffff_ffff, plc_pkg::OFS_DIV,    32'h0000_3fff},
        '{plc_pkg::OFS_HYST,   32'hffff_ffff, plc_pkg::OFS_HYST,   32'h00ff_ffff},
        '{9'h0e0,              32'hffff_ffff, 9'h0e0,              32'h0000_0000},
        '{plc_pkg::OFS_GF_EN,  32'hffff_ffff, plc_pkg::OFS_GF_ST,  32'h00ff_ffff},
        '{plc_pkg::OFS_GF_DIS, 32'h0000_ffff, plc_pkg::OFS_GF_ST,  32'h00ff_0000},
        '{plc_pkg::OFS_SF_EN,  32'h0f00_00f0, plc_pkg::OFS_SF_ST,  32'h0000_00f0},
        '{plc_pkg::OFS_PD_EN,  32'h0100_0100, plc_pkg::OFS_PD_ST,  32'h0000_0130},
        '{plc_pkg::OFS_PD_DIS, 32'h0000_0100, plc_pkg::OFS_PD_ST,  32'h0000_0030},
        '{plc_pkg::OFS_OE_EN,  32'hffff_ffff, plc_pkg::OFS_OE_ST,  32'h00ff_ffff},
        '{plc_pkg::OFS_OE_DIS, 32'hffff_0000, plc_pkg::OFS_OE_ST,  32'h0000_ffff},
        '{plc_pkg::OFS_OWN_DIS,32'h0000_ffff, plc_pkg::OFS_OWN_ST, 32'h0000_ff00},
        '{plc_pkg::OFS_OWN_EN, 32'h0000_0030, plc_pkg::OFS_OWN_ST, 32'h0000_ff30},
        '{plc_pkg::OFS_OUT_SET,32'h0000_00ff, plc_pkg::OFS_OUT_ST, 32'h0000_00ff},
        '{plc_pkg::OFS_OUT_CLR,32'h0000_000f, plc_pkg::OFS_OUT_ST, 32'h0000_00f0},
        '{plc_pkg::OFS_OUT_ST, 32'h0000_ff00, plc_pkg::OFS_OUT_ST, 32'h0000_00f0},
        '{plc_pkg::OFS_OW_EN,  32'h0000_0f0f, plc_pkg::OFS_OW_ST,  32'h0000_0f0f},
        '{plc_pkg::OFS_OUT_ST, 32'hffff_ffff, plc_pkg::OFS_OUT_ST, 32'h0000_0fff},
        '{plc_pkg::OFS_SEL_HI, 32'h1234_5678, plc_pkg::OFS_SEL_HI, 32'h0034_5678},
        '{plc_pkg::OFS_SF_DIS, 32'h0000_0030, plc_pkg::OFS_SF_ST,  32'h0000_00c0},
        '{plc_pkg::OFS_OW_DIS, 32'h0000_0f00, plc_pkg::OFS_OW_ST,  32'h0000_000f}};

    always #25 CLK = ~CLK;

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask : wr

    // read data are only valid in the single cycle after the strobe
    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        cmp_word(d, exp);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : settle

    // bounded wait, then the level is judged anyway
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 10 && IRQ !== exp; i++) @(posedge CLK);
        #1;
        cmp_bit(IRQ, exp);
    endtask : wait_irq

    task automatic close_out;
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        close_out;
    end

    initial begin
        CLK = 1'b0;
        NRST = 1'b0;
        CLK_EN = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 9'h000;
        WDATA = 32'h0;
        ext_en = 32'hffff_ffc0;
        ext_val = 32'h0;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0000);
        settle(10);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_000f);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0000);
        cmp_word(OWN_LINES, 32'h0000_ff0f);
        cmp_word(PIN_OE_N, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) rd_chk(RST[i].ra, RST[i].ex);
        for (int i = 0; i < 21; i++) begin
            wr(OPS[i].a, OPS[i].d);
            rd_chk(OPS[i].ra, OPS[i].ex);
        end
        cmp_word(SEL_LO, 32'h00ff_ffff);
        cmp_word(SEL_HI, 32'h0034_5678);
        cmp_word(HYST_EN, 32'h00ff_ffff);
        cmp_word(PULLUP_EN, 32'h0000_000f);
        cmp_word(PULLDN_EN, 32'h0000_0030);
        // lines 4 and 5 go open drain while high, so they are released
        wr(plc_pkg::OFS_OD_EN, 32'h0000_0030);
        settle(2);
        cmp_word(OWN_LINES, 32'h0000_ff30);
        cmp_word(PIN_OUT, 32'h0000_0fff);
        cmp_word(PIN_OE_N, 32'hffff_00ff);
        wr(plc_pkg::OFS_OUT_CLR, 32'h0000_0010);
        settle(2);
        cmp_word(PIN_OE_N, 32'hffff_00ef);
        // pin sample with every driver released
        wr(plc_pkg::OFS_OE_DIS, 32'hffff_ffff);
        ext_val <= 32'h00a5_5a00;
        settle(6);
        rd_chk(plc_pkg::OFS_PIN, 32'h00a5_5a0f);
        @(posedge CLK) CLK_EN <= 1'b0;
        settle(2);
        ext_val <= 32'h0011_2200;
        settle(6);
        rd_chk(plc_pkg::OFS_PIN, 32'h00a5_5a0f);
        @(posedge CLK) CLK_EN <= 1'b1;
        settle(6);
        rd_chk(plc_pkg::OFS_PIN, 32'h0011_220f);
        ext_val <= 32'h0;
        // write guard drops the ownership and drive writes and records the last one
        wr(plc_pkg::OFS_WG_MODE, 32'h0000_0001);
        wr(plc_pkg::OFS_OWN_EN, 32'hffff_ffff);
        wr(plc_pkg::OFS_OE_EN, 32'h0000_0001);
        rd_chk(plc_pkg::OFS_OWN_ST, 32'h0000_ff30);
        rd_chk(plc_pkg::OFS_OE_ST, 32'h0000_0000);
        rd_chk(plc_pkg::OFS_WG_ST, 32'h0000_1001);
        wr(plc_pkg::OFS_WG_MODE, 32'h0000_0000);
        wr(plc_pkg::OFS_OE_EN, 32'h0000_0001);
        rd_chk(plc_pkg::OFS_OE_ST, 32'h0000_0001);
        // edge flag on line 8: raised, read clears, mask gates only the output
        settle(6);
        rd(plc_pkg::OFS_PEND, v);
        wr(plc_pkg::OFS_IE_SET, 32'h0000_0100);
        ext_val <= 32'h0000_0100;
        wait_irq(1'b1);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0100);
        wait_irq(1'b0);
        wr(plc_pkg::OFS_IE_CLR, 32'h0000_0100);
        rd_chk(plc_pkg::OFS_IE_ST, 32'h0000_0000);
        ext_val <= 32'h0;
        settle(6);
        cmp_bit(IRQ, 1'b0);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0100);
        // high level on line 9 keeps coming back after each read
        wr(plc_pkg::OFS_RISE, 32'h0000_0200);
        wr(plc_pkg::OFS_LEVEL, 32'h0000_0200);
        wr(plc_pkg::OFS_AIM_EN, 32'h0000_0200);
        rd_chk(plc_pkg::OFS_EL_ST, 32'h0000_0200);
        rd_chk(plc_pkg::OFS_POL_ST, 32'h0000_0200);
        rd(plc_pkg::OFS_PEND, v);
        ext_val <= 32'h0000_0200;
        settle(6);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0200);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0200);
        wr(plc_pkg::OFS_IE_SET, 32'h0000_0200);
        wait_irq(1'b1);
        ext_val <= 32'h0;
        settle(6);
        rd(plc_pkg::OFS_PEND, v);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0000);
        wait_irq(1'b0);
        // line 9 back to edges, falling only: a rise is ignored, the fall is kept
        wr(plc_pkg::OFS_EDGE, 32'h0000_0200);
        wr(plc_pkg::OFS_FALL, 32'h0000_0200);
        rd_chk(plc_pkg::OFS_EL_ST, 32'h0000_0000);
        rd_chk(plc_pkg::OFS_POL_ST, 32'h0000_0000);
        ext_val <= 32'h0000_0200;
        settle(6);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0000);
        ext_val <= 32'h0;
        settle(6);
        rd_chk(plc_pkg::OFS_PEND, 32'h0000_0200);
        wr(plc_pkg::OFS_AIM_DIS, 32'h0000_0200);
        rd_chk(plc_pkg::OFS_AIM_ST, 32'h0000_0000);
        close_out;
    end
endmodule : parallel_io_register_map_tb_top
`default_nettype wire
